/* logic/adcirq_pkg.sv */
package adcirq_pkg;

  ////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADCIRQ_LINES = 4;
  localparam int ADCIRQ_AW = 6;
  localparam int ADCIRQ_DW = 32;
  localparam int ADCIRQ_TW = 16;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [5:0] ADCIRQ_OFS_PEND = 6'h00;
  localparam logic [5:0] ADCIRQ_OFS_PEND_CLR = 6'h04;
  localparam logic [5:0] ADCIRQ_OFS_OVF = 6'h08;
  localparam logic [5:0] ADCIRQ_OFS_OVF_CLR = 6'h0C;
  localparam logic [5:0] ADCIRQ_OFS_CONT = 6'h10;
  localparam logic [5:0] ADCIRQ_OFS_MODE = 6'h14;
  localparam logic [5:0] ADCIRQ_OFS_TRIM_ACT = 6'h18;
  localparam logic [5:0] ADCIRQ_OFS_STAT = 6'h1C;
  localparam logic [5:0] ADCIRQ_OFS_MASK = 6'h20;
  // four trim slots, one per mode index, from here in steps of four
  localparam logic [5:0] ADCIRQ_OFS_TRIM0 = 6'h30;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ADCIRQ_MODE_RES16_BIT = 0;
  localparam int ADCIRQ_MODE_DIFF_BIT = 1;
  localparam int ADCIRQ_STAT_FIRE_POS = 0;
  localparam int ADCIRQ_STAT_OVF_POS = 4;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [3:0] ADCIRQ_CONT_RST = 4'h0;
  localparam logic [3:0] ADCIRQ_MASK_RST = 4'h0;
  // mode index 0 is 12-bit single-ended
  localparam logic [1:0] ADCIRQ_MODE_RST = 2'h0;
  // slot defaults, index = {diff, res16}
  localparam logic [3:0][15:0] ADCIRQ_TRIM_RST =
    {16'h0003, 16'h0002, 16'h0001, 16'h0000};

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [3:0] adcirq_lines_t;
  typedef logic [1:0] adcirq_mode_t;
  typedef logic [7:0] adcirq_stat_t;
  typedef enum logic {ADCIRQ_BUS_IDLE, ADCIRQ_BUS_ANSWER} adcirq_bus_e;

endpackage

/* logic/adcirq_line_if.sv */
`timescale 1ns/1ps
interface adcirq_line_if;
  import adcirq_pkg::*;
  adcirq_lines_t conv_ev;
  adcirq_lines_t clr_pend;
  adcirq_lines_t clr_ovf;
  adcirq_lines_t cont;
  adcirq_lines_t pend;
  adcirq_lines_t ovf;
  adcirq_lines_t fire;
  adcirq_lines_t new_ovf;
  modport flags (
    input conv_ev, clr_pend, clr_ovf, cont,
    output pend, ovf, fire, new_ovf
  );
  modport ctrl (
    output conv_ev, clr_pend, clr_ovf, cont,
    input pend, ovf, fire, new_ovf
  );
endinterface

/* logic/adcirq_flags.sv */
`timescale 1ns/1ps
module adcirq_flags (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control side
  adcirq_line_if.flags lines,
  // interrupt pulses per line
  output adcirq_pkg::adcirq_lines_t conv_irq_line
);
  import adcirq_pkg::*;

  adcirq_lines_t pend_q;
  adcirq_lines_t ovf_q;
  adcirq_lines_t fire_q;

  assign lines.pend = pend_q;
  assign lines.ovf = ovf_q;
  assign conv_irq_line = fire_q;

  //////////////////////////////////////////////////////////////////////////
  genvar i;
  for (i = 0; i < ADCIRQ_LINES; i++)
  begin : g_line
    logic hit_pend;
    assign hit_pend = lines.conv_ev[i] & pend_q[i];
    assign lines.fire[i] =
      lines.conv_ev[i] & (lines.cont[i] | ~pend_q[i]);
    assign lines.new_ovf[i] = hit_pend;

    // a new event beats a clear in the same cycle
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        pend_q[i] <= 1'b0;
      else
        pend_q[i] <= (pend_q[i] & ~lines.clr_pend[i])
          | lines.conv_ev[i];
    end

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        ovf_q[i] <= 1'b0;
      else
        ovf_q[i] <= (ovf_q[i] & ~lines.clr_ovf[i]) | hit_pend;
    end

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        fire_q[i] <= 1'b0;
      else
        fire_q[i] <= lines.fire[i];
    end

    sequence s_ev_on_pend;
      lines.conv_ev[i] && pend_q[i];
    endsequence

    sequence s_clear_alone;
      lines.clr_pend[i] && !lines.conv_ev[i];
    endsequence

    cont_fires_a: assert property (@(posedge clk) disable iff (reset)
      lines.conv_ev[i] && lines.cont[i] |=> fire_q[i])
      else $error("continue line did not fire");
    blocked_silent_a: assert property (@(posedge clk)
      disable iff (reset)
      lines.conv_ev[i] && pend_q[i] && !lines.cont[i]
        |=> !fire_q[i] && pend_q[i])
      else $error("pending line fired without continue");
    pend_clear_a: assert property (@(posedge clk) disable iff (reset)
      s_clear_alone |=> !pend_q[i])
      else $error("pending flag not cleared");
    ovf_hold_a: assert property (@(posedge clk) disable iff (reset)
      ovf_q[i] && !lines.clr_ovf[i] |=> ovf_q[i])
      else $error("overflow flag lost");
    ovf_clear_a: assert property (@(posedge clk) disable iff (reset)
      lines.clr_ovf[i] && !hit_pend |=> !ovf_q[i])
      else $error("overflow flag not cleared");
    ovf_set_a: assert property (@(posedge clk) disable iff (reset)
      s_ev_on_pend |=> ovf_q[i] ##1 (ovf_q[i] || $past(lines.clr_ovf[i])))
      else $error("overflow not set on lost event");
  end

endmodule // adcirq_flags

/* logic/adcirq_top.sv */
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// Behaviour
// - continue setting keeps line interrupts firing
// - without continue, pending flag blocks line
// - write one to pending clear clears
// - lost event sets readable overflow flag
// - write one to overflow clear clears
// - offset trim follows resolution and signalling
// - reset selects 12-bit single-ended trim
module adcirq_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [adcirq_pkg::ADCIRQ_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [adcirq_pkg::ADCIRQ_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [adcirq_pkg::ADCIRQ_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // converter events and interrupt lines
  input wire adcirq_pkg::adcirq_lines_t conv_event,
  output adcirq_pkg::adcirq_lines_t conv_irq_line,
  output logic irq,
  // analog trim and mode
  output logic [adcirq_pkg::ADCIRQ_TW-1:0] offset_trim,
  output logic res_16bit,
  output logic diff_mode
);
  import adcirq_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++)
      m[b*8 +: 8] = {8{be[b]}};
    return m;
  endfunction

  // {hit, slot} for the four trim slots
  function automatic logic [2:0] trim_slot(input logic [5:0] a);
    logic [5:0] rel;
    rel = a - ADCIRQ_OFS_TRIM0;
    trim_slot = {(a >= ADCIRQ_OFS_TRIM0) && (rel[5:4] == 2'h0)
                 && (rel[1:0] == 2'h0), rel[3:2]};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // declarations

  adcirq_line_if lif ();

  adcirq_bus_e bus_q;
  logic waitreq_q;
  logic [31:0] readdata_q;
  logic [31:0] rdata_d;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic wr_go;
  logic rd_go;
  logic [2:0] wslot;
  logic [2:0] rslot;

  adcirq_lines_t cont_q;
  adcirq_mode_t mode_q;
  logic [3:0][15:0] trim_tab_q;
  logic [15:0] trim_q;
  adcirq_stat_t stat_q;
  adcirq_stat_t stat_d;
  adcirq_stat_t stat_clr;
  adcirq_stat_t mask_q;
  logic irq_q;

  //////////////////////////////////////////////////////////////////////////
  // flag engine

  adcirq_flags u_flags (
    .clk(clk),
    .reset(reset),
    .lines(lif.flags),
    .conv_irq_line(conv_irq_line)
  );

  assign lif.conv_ev = conv_event;
  assign lif.cont = cont_q;

  //////////////////////////////////////////////////////////////////////////
  // avalon-mm handshake: one wait cycle, then the answer edge

  assign wmask = lane_mask(avs_byteenable);
  assign wd = avs_writedata & wmask;
  // writes act only on the edge where waitrequest is seen low
  assign wr_go = avs_write && (bus_q == ADCIRQ_BUS_ANSWER);
  assign rd_go = avs_read && (bus_q == ADCIRQ_BUS_IDLE);
  assign wslot = trim_slot(avs_address);
  assign rslot = trim_slot(avs_address);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bus_q <= ADCIRQ_BUS_IDLE;
    else
      case (bus_q)
        ADCIRQ_BUS_IDLE:
          if (avs_read || avs_write)
            bus_q <= ADCIRQ_BUS_ANSWER;
        ADCIRQ_BUS_ANSWER:
          bus_q <= ADCIRQ_BUS_IDLE;
        default:
          bus_q <= ADCIRQ_BUS_IDLE;
      endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      waitreq_q <= 1'b1;
    else if (bus_q == ADCIRQ_BUS_IDLE && (avs_read || avs_write))
      waitreq_q <= 1'b0;
    else
      waitreq_q <= 1'b1;
  end

  // read data is caught on the first edge and stands through the answer
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      ADCIRQ_OFS_PEND: rdata_d[3:0] = lif.pend;
      ADCIRQ_OFS_OVF: rdata_d[3:0] = lif.ovf;
      ADCIRQ_OFS_CONT: rdata_d[3:0] = cont_q;
      ADCIRQ_OFS_MODE: rdata_d[1:0] = mode_q;
      ADCIRQ_OFS_TRIM_ACT: rdata_d[15:0] = trim_q;
      ADCIRQ_OFS_STAT: rdata_d[7:0] = stat_q;
      ADCIRQ_OFS_MASK: rdata_d[7:0] = mask_q;
      default:
        if (rslot[2])
          rdata_d[15:0] = trim_tab_q[rslot[1:0]];
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      readdata_q <= 32'h0000_0000;
    else if (rd_go)
      readdata_q <= rdata_d;
  end

  assign avs_waitrequest = waitreq_q;
  assign avs_readdata = readdata_q;

  //////////////////////////////////////////////////////////////////////////
  // clear strobes, one-shot on the answer edge

  assign lif.clr_pend = (wr_go && avs_address == ADCIRQ_OFS_PEND_CLR)
                        ? wd[3:0] : 4'h0;
  assign lif.clr_ovf = (wr_go && avs_address == ADCIRQ_OFS_OVF_CLR)
                       ? wd[3:0] : 4'h0;

  //////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cont_q <= ADCIRQ_CONT_RST;
    else if (wr_go && avs_address == ADCIRQ_OFS_CONT)
      cont_q <= (cont_q & ~wmask[3:0]) | wd[3:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mode_q <= ADCIRQ_MODE_RST;
    else if (wr_go && avs_address == ADCIRQ_OFS_MODE)
      mode_q <= (mode_q & ~wmask[1:0]) | wd[1:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mask_q <= {ADCIRQ_MASK_RST, ADCIRQ_MASK_RST};
    else if (wr_go && avs_address == ADCIRQ_OFS_MASK)
      mask_q <= (mask_q & ~wmask[7:0]) | wd[7:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      trim_tab_q <= ADCIRQ_TRIM_RST;
    else if (wr_go && wslot[2])
      trim_tab_q[wslot[1:0]] <=
        (trim_tab_q[wslot[1:0]] & ~wmask[15:0]) | wd[15:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // offset trim: reselected every cycle, so a mode change or slot
  // rewrite reaches the converter one clock later

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      trim_q <= ADCIRQ_TRIM_RST[ADCIRQ_MODE_RST];
    else
      trim_q <= trim_tab_q[mode_q];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      res_16bit <= ADCIRQ_MODE_RST[ADCIRQ_MODE_RES16_BIT];
      diff_mode <= ADCIRQ_MODE_RST[ADCIRQ_MODE_DIFF_BIT];
    end
    else
    begin
      res_16bit <= mode_q[ADCIRQ_MODE_RES16_BIT];
      diff_mode <= mode_q[ADCIRQ_MODE_DIFF_BIT];
    end
  end

  assign offset_trim = trim_q;

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  assign stat_clr = (wr_go && avs_address == ADCIRQ_OFS_STAT)
                    ? wd[7:0] : 8'h00;

  // new events win over a write-one clear in the same cycle
  always_comb
  begin
    stat_d = stat_q & ~stat_clr;
    stat_d[ADCIRQ_STAT_FIRE_POS +: 4] =
      stat_d[ADCIRQ_STAT_FIRE_POS +: 4] | lif.fire;
    stat_d[ADCIRQ_STAT_OVF_POS +: 4] =
      stat_d[ADCIRQ_STAT_OVF_POS +: 4] | lif.new_ovf;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      stat_q <= 8'h00;
    else
      stat_q <= stat_d;
  end

  // registered one cycle behind status so the pin is glitch free
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end

  assign irq = irq_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_req_start;
    bus_q == ADCIRQ_BUS_IDLE && (avs_read || avs_write);
  endsequence

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (@(posedge clk) disable iff (reset)
    s_req_start |=> s_answer)
    else $error("bus answer not after one wait cycle");

  trim_follow_a: assert property (@(posedge clk) disable iff (reset)
    $changed(mode_q) |=> offset_trim == trim_tab_q[$past(mode_q)])
    else $error("trim did not follow mode change");

  trim_start_a: assert property (@(posedge clk)
    $past(reset) && !reset |-> offset_trim == ADCIRQ_TRIM_RST[0]
      && !res_16bit && !diff_mode)
    else $error("start-up trim not 12-bit single-ended");

  stat_sticky_a: assert property (@(posedge clk) disable iff (reset)
    lif.fire[0] |=> stat_q[ADCIRQ_STAT_FIRE_POS] ##1
      (stat_q[ADCIRQ_STAT_FIRE_POS] || $past(stat_clr[0])))
    else $error("status bit not sticky");

  irq_level_a: assert property (@(posedge clk) disable iff (reset)
    (stat_q & mask_q) != 8'h00 && $stable(stat_q) && $stable(mask_q)
      |=> irq)
    else $error("unmasked status without interrupt");

endmodule // adcirq_top

/* test/tb_adc_interrupt_flag_and_trim.sv */
`timescale 1ns/1ps
module tb_adc_interrupt_flag_and_trim;
  import adcirq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic clk;
  logic reset;
  logic [ADCIRQ_AW-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [ADCIRQ_DW-1:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [ADCIRQ_DW-1:0] avs_readdata;
  logic avs_waitrequest;
  adcirq_lines_t conv_event;
  adcirq_lines_t conv_irq_line;
  logic irq;
  logic [ADCIRQ_TW-1:0] offset_trim;
  logic res_16bit;
  logic diff_mode;
  int n_mismatch;
  int check_count;
  int cycles;
  logic [31:0] rd;
  adcirq_lines_t pulse;

  adcirq_top adcirq_top_inst (
    .clk(clk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .conv_event(conv_event),
    .conv_irq_line(conv_irq_line),
    .irq(irq),
    .offset_trim(offset_trim),
    .res_16bit(res_16bit),
    .diff_mode(diff_mode)
  );

  ////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;

  // whole run is under two hundred cycles, so this ceiling only trips on a hang
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input string what, input logic [5:0] a,
                      input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  // one-cycle event, returns the interrupt pulse seen one cycle later
  task automatic ev(input adcirq_lines_t l, output adcirq_lines_t p);
    @(posedge clk);
    conv_event <= l;
    @(posedge clk);
    conv_event <= 4'h0;
    #1;
    p = conv_irq_line;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    conv_event = 4'h0;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;

    rchk("cont reset", ADCIRQ_OFS_CONT, 32'h0);
    rchk("mode reset", ADCIRQ_OFS_MODE, 32'h0);
    rchk("trim act reset", ADCIRQ_OFS_TRIM_ACT, 32'h0);
    chk("offset_trim reset", 32'h0, {16'h0, offset_trim});
    chk("res diff reset", 32'h0, {30'h0, diff_mode, res_16bit});
    rchk("mask reset", ADCIRQ_OFS_MASK, 32'h0);
    rchk("pend reset", ADCIRQ_OFS_PEND, 32'h0);
    rchk("unmapped read", 6'h2C, 32'h0);
    $display("test reset done");

    // without continue a pending flag blocks the line
    ev(4'h1, pulse);
    chk("first pulse", 32'h1, {28'h0, pulse});
    rchk("pend set", ADCIRQ_OFS_PEND, 32'h1);
    rchk("ovf clear", ADCIRQ_OFS_OVF, 32'h0);
    ev(4'h1, pulse);
    chk("blocked pulse", 32'h0, {28'h0, pulse});
    rchk("ovf set", ADCIRQ_OFS_OVF, 32'h1);
    wr(ADCIRQ_OFS_PEND_CLR, 32'h0);
    rchk("pend after zero", ADCIRQ_OFS_PEND, 32'h1);
    wr(ADCIRQ_OFS_PEND_CLR, 32'h1);
    rchk("pend cleared", ADCIRQ_OFS_PEND, 32'h0);
    ev(4'h1, pulse);
    chk("pulse reopened", 32'h1, {28'h0, pulse});
    wr(ADCIRQ_OFS_OVF_CLR, 32'h0);
    rchk("ovf after zero", ADCIRQ_OFS_OVF, 32'h1);
    wr(ADCIRQ_OFS_OVF_CLR, 32'h1);
    rchk("ovf cleared", ADCIRQ_OFS_OVF, 32'h0);
    $display("test blocking done");

    // lines 1..3 continue, line 0 still pending and blocked
    wr(ADCIRQ_OFS_CONT, 32'hE);
    rchk("cont", ADCIRQ_OFS_CONT, 32'hE);
    // lane 0 disabled: the write must not reach the line bits
    avs_byteenable <= 4'hE;
    wr(ADCIRQ_OFS_CONT, 32'h1);
    avs_byteenable <= 4'hF;
    rchk("cont lanes", ADCIRQ_OFS_CONT, 32'hE);
    ev(4'hF, pulse);
    chk("cont pulse 1", 32'hE, {28'h0, pulse});
    ev(4'hF, pulse);
    chk("cont pulse 2", 32'hE, {28'h0, pulse});
    rchk("ovf all", ADCIRQ_OFS_OVF, 32'hF);
    // software clear sequence: clear, recheck overflow, clear again
    wr(ADCIRQ_OFS_PEND_CLR, 32'hF);
    bus(1'b0, ADCIRQ_OFS_OVF, 32'h0, rd);
    chk("ovf recheck", 32'hF, rd);
    if (rd[3:0] !== 4'h0)
      wr(ADCIRQ_OFS_PEND_CLR, 32'hF);
    rchk("pend all clear", ADCIRQ_OFS_PEND, 32'h0);
    wr(ADCIRQ_OFS_OVF_CLR, 32'hF);
    rchk("ovf all clear", ADCIRQ_OFS_OVF, 32'h0);
    $display("test continue done");

    // each mode index picks its own trim slot
    for (int m = 0; m < 4; m++)
    begin
      wr(ADCIRQ_OFS_MODE, 32'(m));
      rchk("trim act", ADCIRQ_OFS_TRIM_ACT,
           {16'h0, ADCIRQ_TRIM_RST[m]});
      chk("offset_trim", {16'h0, ADCIRQ_TRIM_RST[m]},
          {16'h0, offset_trim});
      chk("res diff", 32'(m), {30'h0, diff_mode, res_16bit});
    end
    wr(ADCIRQ_OFS_TRIM0 + 6'h0C, 32'h1234);
    rchk("trim slot", ADCIRQ_OFS_TRIM0 + 6'h0C, 32'h1234);
    chk("trim rewrite", 32'h1234, {16'h0, offset_trim});
    wr(ADCIRQ_OFS_MODE, 32'h0);
    // the trim is reselected one clock after the mode write lands
    repeat (2) @(posedge clk);
    #1;
    chk("trim back", {16'h0, ADCIRQ_TRIM_RST[ADCIRQ_MODE_RST]},
        {16'h0, offset_trim});
    $display("test trim done");

    // interrupt output: raise, mask, clear
    wr(ADCIRQ_OFS_STAT, 32'hFF);
    ev(4'h2, pulse);
    chk("irq pulse", 32'h2, {28'h0, pulse});
    repeat (2) @(posedge clk);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADCIRQ_OFS_MASK, 32'h02);
    repeat (2) @(posedge clk);
    #1;
    chk("irq raised", 32'h1, {31'h0, irq});
    rchk("stat", ADCIRQ_OFS_STAT, 32'h02);
    wr(ADCIRQ_OFS_STAT, 32'h02);
    repeat (2) @(posedge clk);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");

    report_and_stop();
  end
endmodule // tb_adc_interrupt_flag_and_trim
